// File: core/smsc_regs.vh
`ifndef SMSC_REGS_VH
`define SMSC_REGS_VH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define SMSC_OFS_ENABLE 8'h00
`define SMSC_OFS_XFER 8'h04
`define SMSC_OFS_BUF 8'h08
`define SMSC_OFS_MODE 8'h0C

// ----------------------------------------
// field positions
// ----------------------------------------
`define SMSC_EN_BIT 7
`define SMSC_GO_BIT 7
`define SMSC_ABORT_BIT 6
`define SMSC_DIR_HI 5
`define SMSC_DIR_LO 4
`define SMSC_XFER_ONE_BIT 3
`define SMSC_CKSEL_HI 2
`define SMSC_CKSEL_LO 0
`define SMSC_IFMODE_HI 3
`define SMSC_IFMODE_LO 2
`define SMSC_BUSY_BIT 3
`define SMSC_SHIFT_BIT 2

// ----------------------------------------
// encodings
// ----------------------------------------
`define SMSC_DIR_TX 2'h0
`define SMSC_DIR_RSVD 2'h1
`define SMSC_DIR_TXRX 2'h2
`define SMSC_DIR_RX 2'h3
`define SMSC_IF_PORT 2'h0
`define SMSC_IF_SIO 2'h1
`define SMSC_IF_BUS 2'h2
`define SMSC_CK_EXT 3'h7

// ----------------------------------------
// reset values and timing
// ----------------------------------------
`define SMSC_RST_CKSEL 3'h1
`define SMSC_RST_DIR 2'h0
`define SMSC_RST_IFMODE 2'h0
`define SMSC_DIV_EXP_BASE 4'h3
`define SMSC_FRAME_BITS 4'h8
`define SMSC_STATUS_ONES 8'hF3

`endif

// File: core/smsc_clkdiv.v
`timescale 1ns/1ps
`include "smsc_regs.vh"

// internal serial clock: period 2^n system clocks, n = code + 3
module smsc_clkdiv (
	// system
	input wire clk,
	input wire rstn,
	// control
	input wire run,
	input wire [2:0] code,
	// serial clock
	output reg sck_reg,
	output wire lead,
	output wire trail
);

reg [8:0] cnt_reg;
wire [3:0] exp_n;
wire [8:0] half_last;
wire tick;

assign exp_n = {1'b0, code} + `SMSC_DIV_EXP_BASE;
// half period is 2^(n-1) cycles
assign half_last = (9'h001 << (exp_n - 4'h1)) - 9'h001;
assign tick = run && (cnt_reg == half_last);
assign lead = tick && sck_reg;
assign trail = tick && !sck_reg;

// ----------------------------------------
// divider
// ----------------------------------------
// idle level is high so the first edge of a frame is the falling one
always @(posedge clk or negedge rstn) begin
	if (!rstn) begin
		cnt_reg <= 9'h000;
		sck_reg <= 1'b1;
	end else if (!run) begin
		cnt_reg <= 9'h000;
		sck_reg <= 1'b1;
	end else if (tick) begin
		cnt_reg <= 9'h000;
		sck_reg <= !sck_reg;
	end else begin
		cnt_reg <= cnt_reg + 9'h001;
	end
end

endmodule // smsc_clkdiv

// File: core/smsc_shift.v
`timescale 1ns/1ps
`include "smsc_regs.vh"

// one 8-bit frame, msb first out, lsb-aligned in
module smsc_shift (
	// system
	input wire clk,
	input wire rstn,
	// control
	input wire load,
	input wire abort,
	input wire [7:0] load_data,
	input wire lead,
	input wire trail,
	// serial data
	input wire si,
	output reg so_reg,
	// result
	output reg [7:0] rx_reg,
	output reg busy_reg,
	output reg done_reg
);

reg [7:0] tx_sh_reg;
reg [3:0] cnt_reg;

always @(posedge clk or negedge rstn) begin
	if (!rstn) begin
		tx_sh_reg <= 8'h00;
		rx_reg <= 8'h00;
		cnt_reg <= 4'h0;
		so_reg <= 1'b1;
		busy_reg <= 1'b0;
		done_reg <= 1'b0;
	end else begin
		done_reg <= 1'b0;
		if (abort) begin
			busy_reg <= 1'b0;
			so_reg <= 1'b1;
		end else if (load) begin
			tx_sh_reg <= load_data;
			cnt_reg <= 4'h0;
			busy_reg <= 1'b1;
		end else if (busy_reg && lead) begin
			so_reg <= tx_sh_reg[7];
			tx_sh_reg <= {tx_sh_reg[6:0], 1'b0};
		end else if (busy_reg && trail) begin
			rx_reg <= {rx_reg[6:0], si};
			cnt_reg <= cnt_reg + 4'h1;
			if (cnt_reg == `SMSC_FRAME_BITS - 4'h1) begin
				busy_reg <= 1'b0;
				done_reg <= 1'b1;
			end
		end
	end
end

endmodule // smsc_shift

// File: core/smsc_top.v
// Our own choices: strobed register access and the register addresses.
`timescale 1ns/1ps
`include "smsc_regs.vh"

module smsc_top (
	// system
	input wire clk,
	input wire rstn,
	// register port
	input wire [7:0] addr,
	input wire [31:0] wdata,
	input wire wr_en,
	input wire rd_en,
	output reg [31:0] rdata_reg,
	// serial clock pin
	input wire sck_in,
	output wire sck_out,
	output wire sck_oe,
	// serial data pins
	input wire si,
	output wire so_out,
	output wire so_oe
);

// ----------------------------------------
// state
// ----------------------------------------
localparam ST_IDLE = 2'h0;
localparam ST_SHIFT = 2'h1;
localparam ST_DONE = 2'h2;

reg unit_enable_reg;
reg transfer_go_reg;
reg transfer_abort_reg;
reg [1:0] transfer_direction_select_reg;
reg [2:0] clock_select_reg;
reg [1:0] interface_mode_select_reg;
reg clock_select_written_reg;
reg sio_seen_reg;
reg [7:0] tx_buf_reg;
reg tx_full_reg;
reg [7:0] buffer_byte_reg;
reg rx_full_reg;
reg [1:0] state_reg;
reg [1:0] state_next;
reg sck_q_reg;
reg [31:0] rdata_next;

wire sio_active;
wire ext_clk;
wire dir_valid;
wire need_tx;
wire need_rx;
wire frame_ready;
wire frame_load;
wire abort_now;
wire div_run;
wire div_sck;
wire div_lead;
wire div_trail;
wire ext_lead;
wire ext_trail;
wire lead;
wire trail;
wire sh_so;
wire [7:0] sh_rx;
wire sh_busy;
wire sh_done;
wire cfg_wr;
wire wr_enable;
wire wr_xfer;
wire wr_buf;
wire wr_mode;
wire rd_buf;
wire [2:0] clock_select_view;

// only mode 01 runs the SIO logic
assign sio_active = unit_enable_reg && (interface_mode_select_reg == `SMSC_IF_SIO);
assign ext_clk = (clock_select_reg == `SMSC_CK_EXT);
// reserved direction code never starts a frame
assign dir_valid = (transfer_direction_select_reg != `SMSC_DIR_RSVD);
assign need_tx = (transfer_direction_select_reg == `SMSC_DIR_TX) ||
	(transfer_direction_select_reg == `SMSC_DIR_TXRX);
assign need_rx = (transfer_direction_select_reg == `SMSC_DIR_RX) ||
	(transfer_direction_select_reg == `SMSC_DIR_TXRX);

// ----------------------------------------
// register decode
// ----------------------------------------
// with the unit off only the enable register takes writes
assign cfg_wr = wr_en && unit_enable_reg;
assign wr_enable = wr_en && (addr == `SMSC_OFS_ENABLE);
assign wr_xfer = cfg_wr && (addr == `SMSC_OFS_XFER);
assign wr_buf = cfg_wr && (addr == `SMSC_OFS_BUF);
assign wr_mode = cfg_wr && (addr == `SMSC_OFS_MODE);
assign rd_buf = rd_en && unit_enable_reg && (addr == `SMSC_OFS_BUF);

// abort acts at once and overrides start
assign abort_now = !sio_active || transfer_abort_reg || (wr_xfer && wdata[`SMSC_ABORT_BIT]);

// automatic wait: no frame until the buffers allow it
assign frame_ready = sio_active && transfer_go_reg && !transfer_abort_reg && dir_valid &&
	(!need_tx || tx_full_reg) && (!need_rx || !rx_full_reg);
assign frame_load = (state_reg == ST_IDLE) && frame_ready;

// ----------------------------------------
// serial clock
// ----------------------------------------
// divider only runs inside an active internal-clock frame
assign div_run = sio_active && !ext_clk && (state_reg == ST_SHIFT) && !abort_now;

smsc_clkdiv u_div (
	.clk(clk),
	.rstn(rstn),
	.run(div_run),
	.code(clock_select_reg),
	.sck_reg(div_sck),
	.lead(div_lead),
	.trail(div_trail)
);

// pin input is taken as synchronous, one register for edge finding
always @(posedge clk or negedge rstn) begin
	if (!rstn) begin
		sck_q_reg <= 1'b1;
	end else begin
		sck_q_reg <= sck_in;
	end
end

// external edges: falling leads, rising trails
assign ext_lead = ext_clk && sck_q_reg && !sck_in;
assign ext_trail = ext_clk && !sck_q_reg && sck_in;
assign lead = ext_clk ? ext_lead : div_lead;
assign trail = ext_clk ? ext_trail : div_trail;

// internal clock drives the pin, idle high between frames
assign sck_out = div_sck;
assign sck_oe = sio_active && !ext_clk;

// ----------------------------------------
// shift engine
// ----------------------------------------
// one 8-bit frame per load, msb first
smsc_shift u_shift (
	.clk(clk),
	.rstn(rstn),
	.load(frame_load),
	.abort(abort_now),
	.load_data(need_tx ? tx_buf_reg : 8'hFF),
	.lead(lead && (state_reg == ST_SHIFT)),
	.trail(trail && (state_reg == ST_SHIFT)),
	.si(si),
	.so_reg(sh_so),
	.rx_reg(sh_rx),
	.busy_reg(sh_busy),
	.done_reg(sh_done)
);

// receive-only leaves the data pin undriven
assign so_out = sh_so;
assign so_oe = sio_active && need_tx;

// ----------------------------------------
// frame sequencer
// ----------------------------------------
always @* begin
	state_next = state_reg;
	case (state_reg)
	ST_IDLE: begin
		if (frame_load) begin
			state_next = ST_SHIFT;
		end
	end
	ST_SHIFT: begin
		if (abort_now) begin
			state_next = ST_IDLE;
		end else if (sh_done) begin
			state_next = ST_DONE;
		end
	end
	ST_DONE: begin
		state_next = ST_IDLE;
	end
	default: begin
		state_next = ST_IDLE;
	end
	endcase
end

always @(posedge clk or negedge rstn) begin
	if (!rstn) begin
		state_reg <= ST_IDLE;
	end else begin
		state_reg <= state_next;
	end
end

// ----------------------------------------
// control registers
// ----------------------------------------
// no clear on disable, settings survive
always @(posedge clk or negedge rstn) begin
	if (!rstn) begin
		unit_enable_reg <= 1'b0;
		transfer_go_reg <= 1'b0;
		transfer_abort_reg <= 1'b0;
		transfer_direction_select_reg <= `SMSC_RST_DIR;
		clock_select_reg <= `SMSC_RST_CKSEL;
		interface_mode_select_reg <= `SMSC_RST_IFMODE;
		clock_select_written_reg <= 1'b0;
		sio_seen_reg <= 1'b0;
	end else begin
		if (wr_enable) begin
			unit_enable_reg <= wdata[`SMSC_EN_BIT];
		end
		if (wr_xfer) begin
			transfer_go_reg <= wdata[`SMSC_GO_BIT] && !wdata[`SMSC_ABORT_BIT];
			transfer_abort_reg <= wdata[`SMSC_ABORT_BIT];
			transfer_direction_select_reg <= wdata[`SMSC_DIR_HI:`SMSC_DIR_LO];
			clock_select_reg <= wdata[`SMSC_CKSEL_HI:`SMSC_CKSEL_LO];
			clock_select_written_reg <= 1'b1;
		end else if (wr_mode && !sio_seen_reg && !clock_select_written_reg &&
			(wdata[`SMSC_IFMODE_HI:`SMSC_IFMODE_LO] == `SMSC_IF_SIO)) begin
			// entering SIO mode turns the reset 1 into 0
			clock_select_reg[0] <= 1'b0;
		end
		if (wr_mode) begin
			interface_mode_select_reg <= wdata[`SMSC_IFMODE_HI:`SMSC_IFMODE_LO];
			if (wdata[`SMSC_IFMODE_HI:`SMSC_IFMODE_LO] == `SMSC_IF_SIO) begin
				sio_seen_reg <= 1'b1;
			end
		end
	end
end

// ----------------------------------------
// data buffers
// ----------------------------------------
// separate write and read buffers
always @(posedge clk or negedge rstn) begin
	if (!rstn) begin
		tx_buf_reg <= 8'h00;
		tx_full_reg <= 1'b0;
		buffer_byte_reg <= 8'h00;
		rx_full_reg <= 1'b0;
	end else begin
		// a new write in the load cycle keeps the buffer full
		if (wr_buf) begin
			tx_buf_reg <= wdata[7:0];
			tx_full_reg <= 1'b1;
		end else if (frame_load && need_tx) begin
			tx_full_reg <= 1'b0;
		end
		if (sh_done && need_rx) begin
			buffer_byte_reg <= sh_rx;
			rx_full_reg <= 1'b1;
		end else if (rd_buf) begin
			rx_full_reg <= 1'b0;
		end
	end
end

// ----------------------------------------
// read data
// ----------------------------------------
// bit 0 of clock select shows 1 until SIO mode was chosen
assign clock_select_view = {clock_select_reg[2:1], clock_select_reg[0] || !sio_seen_reg};

always @* begin
	rdata_next = 32'h00000000;
	case (addr)
	`SMSC_OFS_ENABLE: begin
		rdata_next[`SMSC_EN_BIT] = unit_enable_reg;
	end
	`SMSC_OFS_XFER: begin
		rdata_next[`SMSC_GO_BIT] = transfer_go_reg;
		rdata_next[`SMSC_ABORT_BIT] = transfer_abort_reg;
		rdata_next[`SMSC_DIR_HI:`SMSC_DIR_LO] = transfer_direction_select_reg;
		rdata_next[`SMSC_XFER_ONE_BIT] = 1'b1;
		rdata_next[`SMSC_CKSEL_HI:`SMSC_CKSEL_LO] = clock_select_view;
	end
	`SMSC_OFS_BUF: begin
		rdata_next[7:0] = buffer_byte_reg;
	end
	`SMSC_OFS_MODE: begin
		rdata_next[7:0] = `SMSC_STATUS_ONES;
		rdata_next[`SMSC_BUSY_BIT] = (state_reg != ST_IDLE) || frame_ready;
		rdata_next[`SMSC_SHIFT_BIT] = sh_busy;
	end
	default: begin
		rdata_next = 32'h00000000;
	end
	endcase
end

// read data stand only in the cycle after the strobe
always @(posedge clk or negedge rstn) begin
	if (!rstn) begin
		rdata_reg <= 32'h00000000;
	end else if (rd_en) begin
		rdata_reg <= rdata_next;
	end else begin
		rdata_reg <= 32'h00000000;
	end
end

endmodule // smsc_top

// File: tb/smsc_top_monitor.sv
`timescale 1ns/1ps
// port-level checks of the serial unit, attached by bind
module smsc_top_monitor (
	// system
	input wire clk,
	input wire rstn,
	// register port
	input wire [7:0] addr,
	input wire [31:0] wdata,
	input wire wr_en,
	input wire rd_en,
	input wire [31:0] rdata_reg,
	// serial pins
	input wire sck_in,
	input wire sck_out,
	input wire sck_oe,
	input wire si,
	input wire so_out,
	input wire so_oe
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	property p_rdata_idle; !$past(rd_en) |-> rdata_reg == 32'h0; endproperty
	property p_upper_zero; $past(rd_en) |-> rdata_reg[31:8] == 24'h0; endproperty
	property p_unmapped;
		$past(rd_en) && ($past(addr) > 8'h0C || $past(addr[1:0]) != 2'h0) |-> rdata_reg == 32'h0;
	endproperty
	property p_enable_read; $past(rd_en) && $past(addr) == 8'h00 |-> rdata_reg[6:0] == 7'h0; endproperty
	property p_xfer_bit3; $past(rd_en) && $past(addr) == 8'h04 |-> rdata_reg[3]; endproperty
	property p_status_ones;
		$past(rd_en) && $past(addr) == 8'h0C |-> (rdata_reg[7:0] & 8'hF3) == 8'hF3;
	endproperty
	// abort may cut a low phase short, so only rises are timed
	property p_sck_spacing; $rose(sck_out) |=> $stable(sck_out) [*3]; endproperty
	property p_sck_start_high; $rose(sck_oe) |-> sck_out; endproperty

	a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read slot");
	a_upper_zero: assert property (p_upper_zero) else $error("upper read bits not zero");
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	a_enable_read: assert property (p_enable_read) else $error("enable low bits set");
	a_xfer_bit3: assert property (p_xfer_bit3) else $error("control bit 3 not one");
	a_status_ones: assert property (p_status_ones) else $error("status fixed ones wrong");
	a_sck_spacing: assert property (p_sck_spacing) else $error("serial clock too fast");
	a_sck_start_high: assert property (p_sck_start_high) else $error("clock pin starts low");

	c_frame: cover property ($fell(sck_out));
	c_status: cover property ($past(rd_en) && $past(addr) == 8'h0C);
	c_drive: cover property ($rose(sck_oe));
endmodule // smsc_top_monitor

// File: tb/smsc_peer.sv
`timescale 1ns/1ps
// far-side serial device: shifts out on falling, captures on rising clock
module smsc_peer (
	// system
	input wire clk,
	input wire clr,
	// link
	input wire sck,
	input wire so,
	output reg sck_drv = 1'b1,
	output reg si = 1'b1,
	// control and result
	input wire ext_go,
	input wire [8:0] half,
	input wire [7:0] tx_byte,
	output reg [7:0] rx_byte = 8'h00,
	output reg [3:0] n_rise = 4'h0
);
	reg sck_d = 1'b1;
	reg [3:0] n_fall = 4'h0;
	reg [2:0] hold = 3'h0;
	reg [8:0] t = 9'h0;
	reg [4:0] n_edge = 5'h0;

	always @(posedge clk) begin
		sck_d <= sck;
		if (clr) begin
			n_fall <= 4'h0;
			n_rise <= 4'h0;
			hold <= 3'h0;
			n_edge <= 5'h0;
			t <= 9'h0;
			sck_drv <= 1'b1;
		end else begin
			if (sck_d && !sck && n_fall != 4'h8) begin
				si <= tx_byte[3'h7 - n_fall[2:0]];
				n_fall <= n_fall + 4'h1;
			end
			if (!sck_d && sck) begin
				rx_byte <= {rx_byte[6:0], so};
				n_rise <= n_rise + 4'h1;
			end
			// released line flips once hold time is over, never keeps the last bit
			if (n_rise == 4'h8 && hold != 3'h4)
				hold <= hold + 3'h1;
			if (hold == 3'h3)
				si <= ~si;
			// clock source runs only inside a frame, idle high
			if (ext_go && n_edge != 5'h10) begin
				if (t == half) begin
					t <= 9'h0;
					sck_drv <= ~sck_drv;
					n_edge <= n_edge + 5'h1;
				end else
					t <= t + 9'h1;
			end
		end
	end
endmodule // smsc_peer

// File: tb/smsc_top_test.sv
`timescale 1ns/1ps
module smsc_top_test;
	typedef struct packed {logic wr; logic [7:0] a; logic [31:0] d; logic [31:0] e;} smsc_row_t;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic wr_en = 1'b0;
	logic rd_en = 1'b0;
	logic clr = 1'b1;
	logic ext_go = 1'b0;
	logic [7:0] tx_byte = 8'h00;
	wire [31:0] rdata_reg;
	wire sck_out, sck_oe, so_out, so_oe, sck_drv, si;
	wire [7:0] rx_byte;
	wire [3:0] n_rise;
	wire sck_w = sck_oe ? sck_out : sck_drv;
	// undriven data line shows a changing pattern
	wire so_w = so_oe ? so_out : sck_w;
	int n_errors = 0;
	int num_checks = 0;
	int n;
	logic [31:0] q;
	smsc_row_t rows [10] = '{
		'{1'b0, 8'h00, 32'h00, 32'h00},
		'{1'b1, 8'h04, 32'h65, 32'h09},
		'{1'b1, 8'h00, 32'h80, 32'h80},
		'{1'b1, 8'h0C, 32'h04, 32'hF3}, // never bus mode
		'{1'b0, 8'h04, 32'h00, 32'h08},
		'{1'b1, 8'h04, 32'h65, 32'h6D},
		'{1'b1, 8'h04, 32'h57, 32'h5F},
		'{1'b1, 8'h04, 32'hC2, 32'h4A},
		'{1'b1, 8'h08, 32'hFF, 32'h00},
		'{1'b1, 8'h10, 32'hFF, 32'h00}
	};

	smsc_top i_smsc_top (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr_en(wr_en),
		.rd_en(rd_en), .rdata_reg(rdata_reg), .sck_in(sck_w), .sck_out(sck_out),
		.sck_oe(sck_oe), .si(si), .so_out(so_out), .so_oe(so_oe));
	smsc_peer i_smsc_peer (.clk(clk), .clr(clr), .sck(sck_w), .so(so_w), .sck_drv(sck_drv),
		.si(si), .ext_go(ext_go), .half(9'h7), .tx_byte(tx_byte), .rx_byte(rx_byte),
		.n_rise(n_rise));

	initial begin
		forever #5 clk = ~clk;
	end

	task automatic results;
		if (n_errors == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr_en <= 1'b1;
		@(posedge clk);
		wr_en <= 1'b0;
	endtask

	// data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [31:0] r);
		@(posedge clk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge clk);
		rd_en <= 1'b0;
		#1;
		r = rdata_reg;
	endtask

	task automatic wait_on(input logic use_rx, input logic v, output int cnt);
		cnt = 0;
		while ((use_rx ? (n_rise == 4'h8) : sck_w) !== v) begin
			@(posedge clk);
			#1;
			cnt++;
			if (cnt > 9000) begin
				n_errors++;
				results;
			end
		end
	endtask

	initial begin
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		foreach (rows[i]) begin
			if (rows[i].wr)
				wr(rows[i].a, rows[i].d);
			rd(rows[i].a, q);
			chk("register read", rows[i].e, q);
		end
		// full duplex frame at the fastest internal clock
		tx_byte <= 8'h3C;
		wr(8'h04, 32'h60);
		wr(8'h08, 32'hA5);
		clr <= 1'b0;
		wr(8'h04, 32'hA0);
		wait_on(1'b0, 1'b0, n);
		wait_on(1'b0, 1'b1, n);
		chk("half period code 0", 32'h4, 32'(n));
		rd(8'h0C, q);
		chk("busy flag", 32'h1, {31'h0, q[3]});
		wait_on(1'b1, 1'b1, n);
		repeat (4) @(posedge clk);
		#1;
		chk("byte at far side", 32'hA5, {24'h0, rx_byte});
		rd(8'h08, q);
		chk("received byte", 32'h3C, q);
		// slowest internal clock, then abort in mid-frame
		wr(8'h04, 32'h60);
		wr(8'h04, 32'h46);
		wr(8'h08, 32'h5A);
		clr <= 1'b1;
		wr(8'h04, 32'h86);
		clr <= 1'b0;
		wait_on(1'b0, 1'b0, n);
		wait_on(1'b0, 1'b1, n);
		chk("half period code 6", 32'h100, 32'(n));
		repeat (2) @(posedge clk);
		#1;
		chk("first bit out", 32'h0, {31'h0, rx_byte[0]});
		wr(8'h04, 32'h46);
		repeat (3) @(posedge clk);
		#1;
		chk("clock after abort", 32'h1, {31'h0, sck_out});
		chk("data after abort", 32'h1, {31'h0, so_out});
		rd(8'h0C, q);
		chk("status after abort", 32'hF3, q);
		wr(8'h00, 32'h00);
		rd(8'h04, q);
		chk("kept settings", 32'h4E, q);
		wr(8'h00, 32'h80);
		// reserved direction with start set must stay idle
		wr(8'h04, 32'h57);
		wr(8'h04, 32'h97);
		rd(8'h0C, q);
		chk("reserved direction idle", 32'hF3, q);
		wr(8'h04, 32'h57);
		// receive only on the external clock
		wr(8'h04, 32'h77);
		wr(8'h04, 32'hB7);
		@(posedge clk);
		#1;
		chk("clock pin driven", 32'h0, {31'h0, sck_oe});
		chk("data pin driven", 32'h0, {31'h0, so_oe});
		tx_byte <= 8'hC3;
		clr <= 1'b1;
		@(posedge clk);
		clr <= 1'b0;
		ext_go <= 1'b1;
		wait_on(1'b1, 1'b1, n);
		repeat (6) @(posedge clk);
		ext_go <= 1'b0;
		rd(8'h08, q);
		chk("external clock byte", 32'hC3, q);
		// mid-run reset drops the waiting frame and every setting
		@(posedge clk);
		rstn <= 1'b0;
		@(posedge clk);
		#1;
		chk("clock pin in reset", 32'h1, {31'h0, sck_out});
		chk("data pin in reset", 32'h1, {31'h0, so_out});
		@(posedge clk);
		rstn <= 1'b1;
		rd(8'h04, q);
		chk("control after reset", 32'h09, q);
		rd(8'h0C, q);
		chk("status after reset", 32'hF3, q);
		results;
	end
endmodule // smsc_top_test

bind smsc_top smsc_top_monitor i_smsc_top_monitor (.clk(clk), .rstn(rstn), .addr(addr),
	.wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata_reg(rdata_reg), .sck_in(sck_in),
	.sck_out(sck_out), .sck_oe(sck_oe), .si(si), .so_out(so_out), .so_oe(so_oe));
